// file: design/ddc_channel_filter_chain_ctrl.sv
// channel filter-chain control: registers and stated datapath controls
`timescale 1ns/1ps
`default_nettype none
module ddc_channel_filter_chain_ctrl #(
	parameter int MIX_W = 24,
	parameter int CIC_W = 24,
	parameter int SW = 20
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mixer samples in
	input wire logic mix_valid,
	input wire logic [MIX_W-1:0] mix_i,
	input wire logic [MIX_W-1:0] mix_q,
	input wire logic [2:0] in_exp,
	// rounded mixer samples out
	output logic mixo_valid,
	output logic [SW-1:0] mixo_i,
	output logic [SW-1:0] mixo_q,
	// integrator-comb output in
	input wire logic cic_valid,
	input wire logic [CIC_W-1:0] cic_i,
	input wire logic [CIC_W-1:0] cic_q,
	// compensation filter input out
	output logic cf_valid,
	output logic [SW-1:0] cf_i,
	output logic [SW-1:0] cf_q,
	// programmable filter input in and out
	input wire logic pfin_valid,
	input wire logic [SW-1:0] pfin_i,
	input wire logic [SW-1:0] pfin_q,
	output logic pf_valid,
	output logic [SW-1:0] pf_i,
	output logic [SW-1:0] pf_q,
	// programmable filter result in
	input wire logic res_valid,
	input wire logic [SW-1:0] res_i,
	input wire logic [SW-1:0] res_q,
	// channel output
	output logic out_valid,
	output logic [SW-1:0] out_i,
	output logic [SW-1:0] out_q,
	output logic out_is_real,
	output logic out_is_imag,
	// filter configuration out
	output logic [6:0] prescale_down,
	output logic [3:0] zero_insert_count,
	output logic comp_filter_asym,
	output logic prog_filter_asym,
	output logic half_complex_gang,
	// peak counter source
	input wire logic thresh_hit,
	input wire logic comp_ovf,
	input wire logic prog_ovf,
	output logic peak_event
);
	// control registers
	logic [7:0] shift_q; // up-shift and its enable
	logic [7:0] zero_q; // zero insert count
	logic [7:0] gain_q; // integrator gain control
	logic [7:0] iq_q; // sign pattern and split controls
	logic [7:0] comp_q; // compensation filter control
	logic [7:0] prog_q; // programmable filter control
	logic [7:0] peak_q; // peak source kind
	logic ovf_seen_q; // sticky coarse-gain overflow
	logic [1:0] phase_q; // sign pattern position
	logic [5:0] idx; // word index of the access
	logic wr; // write access phase
	logic setup; // setup phase
	logic mapped; // index hits a register
	logic [7:0] rd_d; // read mux
	logic [2:0] up_shift; // effective mixer up-shift
	logic [2:0] scale; // fine prescale
	logic [2:0] big; // coarse prescale step
	logic [7:0] big_bits; // six bits per coarse step
	logic [7:0] used; // total up-scaling claimed
	logic [7:0] base; // widened base
	logic [2:0] coarse; // post-comb gain exponent
	logic crs_ovf; // this sample overflowed
	logic [SW:0] gi; // gained I with overflow bit
	logic [SW:0] gq; // gained Q with overflow bit
	logic [SW-1:0] cg_i; // coarse gained I
	logic [SW-1:0] cg_q; // coarse gained Q
	logic cg_valid; // coarse gain output valid
	logic [SW-1:0] dly_d [4]; // delay inputs
	logic [SW-1:0] dly_o [4]; // delay outputs
	logic dly_v [4]; // delay input valid
	logic dly_ov [4]; // delay output valid
	logic dly_en [4]; // delay enables

	assign idx = paddr[7:2];
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	// zero-wait slave, every access completes at once
	assign pready = 1'b1;

	// shift up and round one mixer lane to 20 or 16 bits
	function automatic logic [SW-1:0] round_mix(
		input logic [MIX_W-1:0] x,
		input logic [2:0] sh,
		input logic wide
	);
		logic [MIX_W+7:0] s;
		logic [MIX_W+7:0] half;
		begin
			s = {{8{x[MIX_W-1]}}, x} <<< sh;
			half = '0;
			if (wide)
				half[MIX_W-ddc_ctrl_pkg::WIDE_BITS-1] = 1'b1;
			else
				half[MIX_W-ddc_ctrl_pkg::NARROW_BITS-1] = 1'b1;
			s = s + half;
			// bits shifted past the top are lost; the shift comes from the register or from in_exp
			round_mix = s[MIX_W-1 -: SW];
			// narrow rounding leaves the low four bits clear
			if (!wide)
				round_mix[SW-ddc_ctrl_pkg::NARROW_BITS-1:0] = '0;
		end
	endfunction : round_mix

	// gain by 2^c and round to SW bits, top bit flags saturation
	function automatic logic [SW:0] coarse_gain(
		input logic [CIC_W-1:0] x,
		input logic [2:0] c
	);
		logic [CIC_W+8:0] s;
		logic [CIC_W+8:0] t;
		logic [CIC_W+8:0] hi;
		logic [CIC_W+8:0] lo;
		begin
			s = {{9{x[CIC_W-1]}}, x} <<< c;
			t = s + ((CIC_W+9)'(1) << (CIC_W-SW-1));
			// signed shift keeps negative samples negative
			t = $signed(t) >>> (CIC_W-SW);
			hi = (CIC_W+9)'({1'b0, {(SW-1){1'b1}}});
			lo = ~hi;
			if ($signed(t) > $signed(hi))
				coarse_gain = {1'b1, 1'b0, {(SW-1){1'b1}}};
			else if ($signed(t) < $signed(lo))
				coarse_gain = {1'b1, 1'b1, {(SW-1){1'b0}}};
			else
				coarse_gain = {1'b0, t[SW-1:0]};
		end
	endfunction : coarse_gain

	// register writes, masked so unused bits stay zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_q <= ddc_ctrl_pkg::RST_SHIFT;
			zero_q <= ddc_ctrl_pkg::RST_ZERO;
			gain_q <= ddc_ctrl_pkg::RST_GAIN;
			iq_q <= ddc_ctrl_pkg::RST_IQ;
			comp_q <= ddc_ctrl_pkg::RST_COMP;
			prog_q <= ddc_ctrl_pkg::RST_PROG;
			peak_q <= ddc_ctrl_pkg::RST_PEAK;
		end
		else if (ce && wr)
		begin
			case (idx)
				ddc_ctrl_pkg::IDX_SHIFT:
					shift_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_SHIFT;
				ddc_ctrl_pkg::IDX_ZERO:
					zero_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_ZERO;
				ddc_ctrl_pkg::IDX_GAIN:
					gain_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_GAIN;
				ddc_ctrl_pkg::IDX_IQ:
					iq_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_IQ;
				// test bit is stored; software keeps it low
				ddc_ctrl_pkg::IDX_COMP:
					comp_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_COMP;
				ddc_ctrl_pkg::IDX_PROG:
					prog_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_PROG;
				ddc_ctrl_pkg::IDX_PEAK:
					peak_q <= pwdata[7:0] & ddc_ctrl_pkg::MSK_PEAK;
				default:
					shift_q <= shift_q;
			endcase
		end
	end

	// read mux over all registers, status included
	always_comb
	begin
		mapped = 1'b1;
		rd_d = '0;
		case (idx)
			ddc_ctrl_pkg::IDX_SHIFT: rd_d = shift_q;
			ddc_ctrl_pkg::IDX_ZERO: rd_d = zero_q;
			ddc_ctrl_pkg::IDX_GAIN: rd_d = gain_q;
			ddc_ctrl_pkg::IDX_IQ: rd_d = iq_q;
			ddc_ctrl_pkg::IDX_COMP: rd_d = comp_q;
			ddc_ctrl_pkg::IDX_PROG: rd_d = prog_q;
			ddc_ctrl_pkg::IDX_PEAK: rd_d = peak_q;
			ddc_ctrl_pkg::IDX_STAT: rd_d = {5'h00, phase_q, ovf_seen_q};
			default: mapped = 1'b0;
		endcase
	end

	// read data and error are sampled in setup for the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else if (ce && setup)
		begin
			prdata <= (!pwrite && mapped) ? {24'h000000, rd_d} : '0;
			pslverr <= !mapped;
		end
	end

	// up-shift: register value when enabled, else input exponent
	assign up_shift = shift_q[ddc_ctrl_pkg::SH_USE] ?
		shift_q[ddc_ctrl_pkg::SH_LO +: 3] : in_exp;

	// rounded mixer output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mixo_valid <= 1'b0;
			mixo_i <= '0;
			mixo_q <= '0;
		end
		else if (ce)
		begin
			mixo_valid <= mix_valid;
			if (mix_valid)
			begin
				mixo_i <= round_mix(mix_i, up_shift,
					gain_q[ddc_ctrl_pkg::WIDE]);
				mixo_q <= round_mix(mix_q, up_shift,
					gain_q[ddc_ctrl_pkg::WIDE]);
			end
		end
	end

	assign scale = gain_q[ddc_ctrl_pkg::SC_LO +: 3];
	assign big = gain_q[ddc_ctrl_pkg::BIG_LO +: 3];
	assign big_bits = 8'(big) * 8'(ddc_ctrl_pkg::BIG_STEP);
	assign used = 8'(up_shift) + 8'(scale) + big_bits;
	assign base = {1'b0, ddc_ctrl_pkg::PRE_BASE};

	// pre-scale amount; bad settings floor at zero, not wrap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale_down <= '0;
		else if (ce)
			prescale_down <= (used > base) ? '0 :
				7'(base - used);
	end

	// static filter configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			zero_insert_count <= '0;
			comp_filter_asym <= 1'b0;
			prog_filter_asym <= 1'b0;
			half_complex_gang <= 1'b0;
		end
		else if (ce)
		begin
			zero_insert_count <= zero_q[3:0];
			comp_filter_asym <= comp_q[ddc_ctrl_pkg::ASYM];
			prog_filter_asym <= prog_q[ddc_ctrl_pkg::ASYM];
			half_complex_gang <= iq_q[ddc_ctrl_pkg::SPLIT];
		end
	end

	// coarse gain after the comb stage
	assign coarse = comp_q[ddc_ctrl_pkg::CRS_LO +: 3];
	assign gi = coarse_gain(cic_i, coarse);
	assign gq = coarse_gain(cic_q, coarse);
	assign crs_ovf = cic_valid && (gi[SW] || gq[SW]);

	// coarse gain output register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cg_valid <= 1'b0;
			cg_i <= '0;
			cg_q <= '0;
		end
		else if (ce)
		begin
			cg_valid <= cic_valid;
			if (cic_valid)
			begin
				cg_i <= gi[SW-1:0];
				cg_q <= gq[SW-1:0];
			end
		end
	end

	// sticky overflow; a new overflow beats a clearing write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ovf_seen_q <= 1'b0;
		else if (ce)
		begin
			if (crs_ovf)
				ovf_seen_q <= 1'b1;
			else if (wr && idx == ddc_ctrl_pkg::IDX_STAT && pwdata[0])
				ovf_seen_q <= 1'b0;
		end
	end

	// delay lanes: 0,1 feed compensation, 2,3 feed programmable
	always_comb
	begin
		dly_d[0] = cg_i;
		dly_d[1] = cg_q;
		dly_d[2] = pfin_i;
		dly_d[3] = pfin_q;
		dly_v[0] = cg_valid;
		dly_v[1] = cg_valid;
		dly_v[2] = pfin_valid;
		dly_v[3] = pfin_valid;
		dly_en[0] = comp_q[ddc_ctrl_pkg::IDLY];
		dly_en[1] = comp_q[ddc_ctrl_pkg::QDLY];
		dly_en[2] = prog_q[ddc_ctrl_pkg::IDLY];
		dly_en[3] = prog_q[ddc_ctrl_pkg::QDLY];
	end

	// one delay stage per lane keeps I and Q latency equal
	for (genvar k = 0; k < 4; k++)
	begin : g_dly
		sample_delay #(
			.W(SW)
		) u_dly (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.delay_en(dly_en[k]),
			.in_valid(dly_v[k]),
			.in_data(dly_d[k]),
			.out_valid(dly_ov[k]),
			.out_data(dly_o[k])
		);
	end

	assign cf_valid = dly_ov[0];
	assign cf_i = dly_o[0];
	assign cf_q = dly_o[1];
	assign pf_valid = dly_ov[2];
	assign pf_i = dly_o[2];
	assign pf_q = dly_o[3];

	// sign pattern position advances once per result
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_q <= '0;
		else if (ce && res_valid)
			phase_q <= phase_q + 2'h1;
	end

	// output stage: sign pattern, split mode and type tags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid <= 1'b0;
			out_i <= '0;
			out_q <= '0;
			out_is_real <= 1'b0;
			out_is_imag <= 1'b0;
		end
		else if (ce)
		begin
			out_valid <= res_valid;
			if (res_valid)
			begin
				out_i <= iq_q[ddc_ctrl_pkg::NEG_LO + phase_q] ?
					SW'(-res_i) : res_i;
				// split mode carries real data only
				if (iq_q[ddc_ctrl_pkg::SPLIT])
					out_q <= '0;
				else
					out_q <= iq_q[ddc_ctrl_pkg::NEG_LO + phase_q] ?
						SW'(-res_q) : res_q;
				out_is_real <= iq_q[ddc_ctrl_pkg::RONLY];
				out_is_imag <= iq_q[ddc_ctrl_pkg::REAL_ONLY_OUTPUT_B];
			end
		end
	end

	// peak source: threshold hits or one chosen overflow
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			peak_event <= 1'b0;
		else if (ce)
		begin
			if (!peak_q[ddc_ctrl_pkg::PMODE])
				peak_event <= thresh_hit;
			else
			begin
				case (prog_q[ddc_ctrl_pkg::PSEL_LO +: 2])
					ddc_ctrl_pkg::PK_COMP: peak_event <= comp_ovf;
					ddc_ctrl_pkg::PK_COARSE: peak_event <= crs_ovf;
					default: peak_event <= prog_ovf;
				endcase
			end
		end
	end
endmodule : ddc_channel_filter_chain_ctrl
`default_nettype wire

// file: design/ddc_ctrl_pkg.sv
// constants for the channel filter-chain control block
// How it works
// - fine prescale field bits 0-2, 0..5
// - coarse prescale bits 3-5, six bits each
// - mixer rounds to 20 or 16 bits
// - prescale down 62-shift-scale-6*coarse bits
// - four-bit sign pattern negates filter outputs
// - split mode passes real data only
// - real-only bit tags samples as real
// - imag-only bit tags samples as imaginary
// - compensation filter asymmetric eleven-tap mode
// - compensation input delays on Q and I
// - coarse gain 2^field before 20-bit rounding
// - programmable filter asymmetric 32-tap mode
// - programmable input delays on Q and I
// - peak select picks overflow source
// - up-shift from register or input exponent
// - peak mode picks threshold or overflow
package ddc_ctrl_pkg;
	// register indices, byte address is four times these
	localparam logic [5:0] IDX_SHIFT = 6'h10;
	localparam logic [5:0] IDX_ZERO = 6'h13;
	localparam logic [5:0] IDX_GAIN = 6'h17;
	localparam logic [5:0] IDX_IQ = 6'h18;
	localparam logic [5:0] IDX_COMP = 6'h19;
	localparam logic [5:0] IDX_PROG = 6'h1a;
	localparam logic [5:0] IDX_PEAK = 6'h1c;
	localparam logic [5:0] IDX_STAT = 6'h20;
	// writable bit masks, other bits read zero
	localparam logic [7:0] MSK_SHIFT = 8'h0f;
	localparam logic [7:0] MSK_ZERO = 8'h0f;
	localparam logic [7:0] MSK_GAIN = 8'h7f;
	localparam logic [7:0] MSK_IQ = 8'h7f;
	localparam logic [7:0] MSK_COMP = 8'hf7;
	localparam logic [7:0] MSK_PROG = 8'h1f;
	localparam logic [7:0] MSK_PEAK = 8'h20;
	// reset values
	localparam logic [7:0] RST_SHIFT = 8'h0c;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_GAIN = 8'h79;
	localparam logic [7:0] RST_IQ = 8'h00;
	localparam logic [7:0] RST_COMP = 8'h00;
	localparam logic [7:0] RST_PROG = 8'h00;
	localparam logic [7:0] RST_PEAK = 8'h20;
	// field positions
	localparam int SH_LO = 0;
	localparam int SH_USE = 3;
	localparam int SC_LO = 0;
	localparam int BIG_LO = 3;
	localparam int WIDE = 6;
	localparam int NEG_LO = 0;
	localparam int SPLIT = 4;
	localparam int RONLY = 5;
	localparam int REAL_ONLY_OUTPUT_B = 6;
	localparam int ASYM = 0;
	localparam int QDLY = 1;
	localparam int IDLY = 2;
	localparam int CRS_LO = 4;
	localparam int PSEL_LO = 3;
	localparam int PMODE = 5;
	// prescale arithmetic
	localparam logic [6:0] PRE_BASE = 7'h3e;
	localparam logic [2:0] BIG_STEP = 3'h6;
	// rounding widths
	localparam int WIDE_BITS = 20;
	localparam int NARROW_BITS = 16;
	// peak overflow sources
	localparam logic [1:0] PK_COMP = 2'h0;
	localparam logic [1:0] PK_COARSE = 2'h1;
endpackage : ddc_ctrl_pkg

// file: design/sample_delay.sv
// optional one-sample delay on a sample stream
`timescale 1ns/1ps
`default_nettype none
module sample_delay #(
	parameter int W = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control
	input wire logic delay_en,
	// stream
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	output logic [W-1:0] out_data
);
	logic [W-1:0] prev_q; // last accepted sample
	// remember each sample so it can be replayed one step late
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_q <= '0;
		else if (ce && in_valid)
			prev_q <= in_data;
	end
	// output stage, registered so both lanes stay aligned
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_data <= '0;
			out_valid <= 1'b0;
		end
		else if (ce)
		begin
			out_valid <= in_valid;
			if (in_valid)
				out_data <= delay_en ? prev_q : in_data;
		end
	end
endmodule : sample_delay
`default_nettype wire

// file: testbench/ddc_ctrl_sva.sv
// assertions on the channel filter-chain control block, with their bind
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_sva #(
	parameter int SW = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// streams
	input wire logic mix_valid,
	input wire logic mixo_valid,
	input wire logic cic_valid,
	input wire logic cf_valid,
	input wire logic pfin_valid,
	input wire logic pf_valid,
	input wire logic res_valid,
	input wire logic out_valid,
	input wire logic [SW-1:0] out_q,
	input wire logic out_is_real,
	input wire logic out_is_imag,
	// configuration and peak source
	input wire logic comp_filter_asym,
	input wire logic prog_filter_asym,
	input wire logic thresh_hit,
	input wire logic comp_ovf,
	input wire logic prog_ovf,
	input wire logic peak_event
);
	logic [7:0] iq_q; // shadow of the split register
	logic [7:0] cmp_q; // shadow of the compensation register
	logic [7:0] prg_q; // shadow of the output filter register
	logic [7:0] pk_q; // shadow of the peak register
	logic src; // source the peak counter should watch
	// follow writes at the same edge the block takes them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			iq_q <= 8'h00;
			cmp_q <= 8'h00;
			prg_q <= 8'h00;
			pk_q <= 8'h20;
		end
		else if (psel && penable && pwrite && ce)
		begin
			if (paddr == 8'h60)
				iq_q <= pwdata[7:0];
			if (paddr == 8'h64)
				cmp_q <= pwdata[7:0];
			if (paddr == 8'h68)
				prg_q <= pwdata[7:0];
			if (paddr == 8'h70)
				pk_q <= pwdata[7:0];
		end
	end
	// coarse overflow is internal, so that select is left out below
	assign src = !pk_q[5] ? thresh_hit : prg_q[4] ? prog_ovf : comp_ovf;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_mix_latency: assert property (
		ce |=> mixo_valid == $past(mix_valid))
		else $error("mixer result not one cycle after its sample");
	a_comp_latency: assert property (
		ce ##1 ce |=> cf_valid == $past(cic_valid, 2))
		else $error("gained sample not two cycles after comb sample");
	a_prog_latency: assert property (
		ce |=> pf_valid == $past(pfin_valid))
		else $error("filter input not one cycle after its sample");
	a_out_latency: assert property (
		ce |=> out_valid == $past(res_valid))
		else $error("channel output not one cycle after result");
	a_split_zero: assert property (
		out_valid && $past(iq_q[4]) |-> out_q == '0)
		else $error("split mode output carries a q value");
	a_real_tag: assert property (
		out_valid |-> out_is_real == $past(iq_q[5]))
		else $error("real tag differs from its bit");
	a_imag_tag: assert property (
		out_valid |-> out_is_imag == $past(iq_q[6]))
		else $error("imaginary tag differs from its bit");
	a_comp_asym: assert property (
		comp_filter_asym == $past(cmp_q[0]))
		else $error("compensation asymmetry not following register");
	a_prog_asym: assert property (
		prog_filter_asym == $past(prg_q[0]))
		else $error("output filter asymmetry not following register");
	a_peak_source: assert property (
		ce && !(pk_q[5] && prg_q[4:3] == 2'h1) |=> peak_event == $past(src))
		else $error("peak event from the wrong source");
	c_split: cover property (out_valid && $past(iq_q[4]));
	c_peak: cover property (peak_event);
	c_asym: cover property (comp_filter_asym && prog_filter_asym);
endmodule : ddc_ctrl_sva
bind ddc_channel_filter_chain_ctrl ddc_ctrl_sva #(.SW(SW)) sva_i (
	.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
	.mix_valid, .mixo_valid, .cic_valid, .cf_valid, .pfin_valid,
	.pf_valid, .res_valid, .out_valid, .out_q, .out_is_real,
	.out_is_imag, .comp_filter_asym, .prog_filter_asym, .thresh_hit,
	.comp_ovf, .prog_ovf, .peak_event
);
`default_nettype wire

// file: testbench/host_model.sv
// host model: an apb master that programs the channel registers
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	// bus idle from time zero
	initial
		{psel, penable, pwrite, paddr, pwdata} = '0;
	// one transfer, held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] rd);
		logic [7:0] v;
		v = d;
		// the test bit is never set by a well-behaved host
		if (w && a == 8'h64)
			v[7] = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the channel filter-chain control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int SW = 20;
	// byte addresses, four times the register index
	localparam logic [7:0] A_SH = 8'h40, A_ZR = 8'h4c, A_GN = 8'h5c;
	localparam logic [7:0] A_IQ = 8'h60, A_CM = 8'h64, A_PR = 8'h68;
	localparam logic [7:0] A_PK = 8'h70, A_ST = 8'h80;
	// clock, reset and inputs, all valued at time zero
	logic pclk = 1'b0, presetn = 1'b0;
	logic mix_valid = 1'b0, cic_valid = 1'b0, ce = 1'b1;
	logic pfin_valid = 1'b0, res_valid = 1'b0;
	logic thresh_hit = 1'b0, comp_ovf = 1'b0, prog_ovf = 1'b0;
	logic [23:0] mix_i = '0, mix_q = '0, cic_i = '0, cic_q = '0;
	logic [SW-1:0] pfin_i = '0, pfin_q = '0, res_i = '0, res_q = '0;
	logic [2:0] in_exp = '0;
	// bus and outputs
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic mixo_valid, cf_valid, pf_valid, out_valid, peak_event;
	logic out_is_real, out_is_imag, half_complex_gang;
	logic comp_filter_asym, prog_filter_asym, pk_seen;
	logic [SW-1:0] mixo_i, mixo_q, cf_i, cf_q, pf_i, pf_q, out_i, out_q;
	logic [6:0] prescale_down;
	logic [3:0] zero_insert_count;
	int n_mismatch = 0, n_checks = 0, cycles = 0, nres = 0;
	always #2.5 pclk = ~pclk;
	ddc_channel_filter_chain_ctrl ddc_channel_filter_chain_ctrl_i (
		.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .mix_valid, .mix_i, .mix_q,
		.in_exp, .mixo_valid, .mixo_i, .mixo_q, .cic_valid, .cic_i,
		.cic_q, .cf_valid, .cf_i, .cf_q, .pfin_valid, .pfin_i, .pfin_q,
		.pf_valid, .pf_i, .pf_q, .res_valid, .res_i, .res_q, .out_valid,
		.out_i, .out_q, .out_is_real, .out_is_imag, .prescale_down,
		.zero_insert_count, .comp_filter_asym, .prog_filter_asym,
		.half_complex_gang, .thresh_hit, .comp_ovf, .prog_ovf, .peak_event);
	host_model host_model_i (.pclk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready);
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// a hung wait counts against the run
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic check(input string w, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic pair(input string w, input logic [SW-1:0] si,
		input logic [SW-1:0] sq, input logic [SW-1:0] ei,
		input logic [SW-1:0] eq);
		check({w, " i"}, si, ei);
		check({w, " q"}, sq, eq);
	endtask : pair
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_model_i.xfer(1'b1, a, d, rdat);
		// configuration outputs follow one edge after the write
		@(posedge pclk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host_model_i.xfer(1'b0, a, 8'h00, rdat);
	endtask : rd
	// one sample into stream s (mixer, comb, filter in, result)
	task automatic send(input int s, input logic [23:0] i,
		input logic [23:0] q);
		@(posedge pclk);
		{mix_valid, cic_valid, pfin_valid, res_valid} <= 4'h8 >> s;
		{mix_i, mix_q, cic_i, cic_q} <= {i, q, i, q};
		{pfin_i, pfin_q, res_i, res_q} <= {2{i[19:0], q[19:0]}};
		@(posedge pclk);
		{mix_valid, cic_valid, pfin_valid, res_valid} <= 4'h0;
		#1;
		pk_seen = peak_event;
		// the comb path has one more register stage
		if (s == 1)
			@(posedge pclk);
		if (s == 3)
			nres++;
		#1;
	endtask : send
	// reset values, writable bits, then a refused index
	task automatic t_regs();
		logic [7:0] a [4];
		logic [7:0] r [4];
		logic [7:0] m [4];
		a = '{A_GN, A_IQ, A_CM, A_PR};
		r = '{8'h79, 8'h00, 8'h00, 8'h00};
		m = '{8'h7f, 8'h7f, 8'h77, 8'h1f};
		foreach (a[k])
		begin
			rd(a[k]);
			check("reset value", rdat, {24'h0, r[k]});
			wr(a[k], 8'hff);
			rd(a[k]);
			check("written value", rdat, {24'h0, m[k]});
			wr(a[k], r[k]);
		end
		rd(8'hfc);
		check("unmapped read", {pslverr, rdat[30:0]}, 32'h80000000);
	endtask : t_regs
	// prescale sums: default, fine step, coarse step of six
	task automatic t_pre();
		check("prescale default", prescale_down, 7'h0f);
		wr(A_GN, 8'h45);
		check("prescale fine", prescale_down, 7'h35);
		wr(A_GN, 8'h48);
		check("prescale coarse", prescale_down, 7'h34);
		wr(A_GN, 8'h79);
		wr(A_ZR, 8'h09);
		check("zero insert", zero_insert_count, 4'h9);
	endtask : t_pre
	// wide and narrow rounding, then shift taken from the exponent
	task automatic t_mix();
		send(0, 24'h000004, 24'hfffff0);
		pair("wide", mixo_i, mixo_q, 20'h00004, 20'hffff0);
		wr(A_GN, 8'h39);
		send(0, 24'h000004, 24'hfffff0);
		pair("narrow", mixo_i, mixo_q, 20'h00000, 20'hffff0);
		wr(A_GN, 8'h79);
		wr(A_SH, 8'h04);
		in_exp <= 3'h5;
		send(0, 24'h000004, 24'h000000);
		pair("exponent", mixo_i, mixo_q, 20'h00008, 20'h0);
		// enable low: a new sample must not reach the output
		ce <= 1'b0;
		send(0, 24'h000010, 24'h000000);
		pair("frozen", mixo_i, mixo_q, 20'h00008, 20'h0);
		ce <= 1'b1;
		wr(A_SH, 8'h0c);
	endtask : t_mix
	// every coarse gain, saturation and its sticky flag
	task automatic t_coarse();
		for (int c = 0; c < 8; c++)
		begin
			wr(A_CM, 8'(c << 4));
			send(1, 24'h000100, 24'hffff00);
			pair("coarse", cf_i, cf_q, SW'(32'h10 << c),
				SW'(-(32'sh10 << c)));
		end
		wr(A_CM, 8'h10);
		wr(A_PK, 8'h20);
		wr(A_PR, 8'h08);
		send(1, 24'h7fffff, 24'h000000);
		check("saturate", cf_i, 20'h7ffff);
		check("coarse peak", pk_seen, 1'b1);
		rd(A_ST);
		check("overflow set", rdat[0], 1'b1);
		wr(A_ST, 8'h01);
		rd(A_ST);
		check("overflow clear", rdat[0], 1'b0);
	endtask : t_coarse
	// lane delays and asymmetry on both filter inputs
	task automatic t_delay();
		logic [2:0] b [3];
		b = '{3'h1, 3'h3, 3'h5};
		foreach (b[k])
		begin
			wr(A_CM, {5'h0, b[k]});
			wr(A_PR, {5'h0, b[k]});
			send(1, 24'h000100, 24'h000100);
			send(1, 24'h000200, 24'h000200);
			pair("comp lane", cf_i, cf_q, b[k][2] ? 20'h10 : 20'h20,
				b[k][1] ? 20'h10 : 20'h20);
			send(2, 24'h000123, 24'h000123);
			send(2, 24'h000456, 24'h000456);
			pair("prog lane", pf_i, pf_q, b[k][2] ? 20'h123 : 20'h456,
				b[k][1] ? 20'h123 : 20'h456);
			check("comp asym", comp_filter_asym, 1'b1);
			check("prog asym", prog_filter_asym, 1'b1);
		end
		wr(A_CM, 8'h00);
	endtask : t_delay
	// sign pattern, split and tags on the channel output
	task automatic t_out();
		logic [7:0] m [3];
		logic [SW-1:0] s;
		logic [SW-1:0] t;
		m = '{8'h25, 8'h4a, 8'h13};
		foreach (m[k])
		begin
			wr(A_IQ, m[k]);
			repeat (5)
			begin
				s = m[k][nres % 4] ? -20'h00123 : 20'h00123;
				t = m[k][nres % 4] ? -20'h00321 : 20'h00321;
				send(3, 24'h000123, 24'h000321);
				pair("out", out_i, out_q, s, m[k][4] ? '0 : t);
				check("real tag", out_is_real, m[k][5]);
				check("imag tag", out_is_imag, m[k][6]);
			end
			check("gang", half_complex_gang, m[k][4]);
		end
	endtask : t_out
	// peak source per mode and select, right source then wrong ones
	task automatic t_peak();
		logic [7:0] pk [5];
		logic [7:0] pr [5];
		logic [2:0] h [5];
		pk = '{8'h00, 8'h20, 8'h20, 8'h20, 8'h00};
		pr = '{8'h00, 8'h00, 8'h10, 8'h18, 8'h18};
		h = '{3'h4, 3'h2, 3'h1, 3'h1, 3'h4};
		foreach (pk[k])
		begin
			wr(A_PK, pk[k]);
			wr(A_PR, pr[k]);
			for (int v = 0; v < 2; v++)
			begin
				{thresh_hit, comp_ovf, prog_ovf} <= v ? ~h[k] : h[k];
				repeat (2) @(posedge pclk);
				#1;
				check("peak event", peak_event, v == 0);
			end
		end
	endtask : t_peak
	// main sequence
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pre();
		t_mix();
		t_coarse();
		t_delay();
		t_out();
		t_peak();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
